// >>> supervision_defines.svh
// constants of the enable and internal supervision block: offsets, fields,
// reset values and timing counts; included by the package and the top.
// Notes on behaviour
// - enable high is valid, low disables
// - enable falling edge raises class A event
// - enable rising clears faults in halt modes
// - other errors may keep device disabled
// - raw enable level and validity readable
// - dies exchange lifesigns, check arrival window
// - lifesign error resets both, asserts class B
// - communication loss sets both sticky flags
// - live secondary ready bit beside sticky flags
// - monitor reference pins and oscillator timing
// - primary reference fault holds primary, reset_ready
// - secondary reference fault: turn-off, then reset
// - configuration registers parity protected, checked continuously
// - primary parity: hold, reset_ready, class B
// - secondary parity: turn-off, reset while present
// - primary parity keeps reset_ready low forever
// - primary oscillator dead: primary held, bus refused
// - secondary oscillator dead: class B, loss, ready 0
// - operable secondary commands gate off, disable works
// - fault and reset_ready outputs are active low
// - every reset event enters default reset mode
// - class A output only on halt transition
`ifndef SUPERVISION_DEFINES_SVH
`define SUPERVISION_DEFINES_SVH

// register byte offsets
`define SUP_OFS_CTRL    8'h00
`define SUP_OFS_STATUS  8'h04
`define SUP_OFS_ERRORS  8'h08
`define SUP_OFS_PCFG    8'h0c
`define SUP_OFS_SCFG    8'h10

// control register fields (write one to act)
`define SUP_CTRL_GO       0
`define SUP_CTRL_MODE_TWO 1
`define SUP_CTRL_CLR_PRIM 2
`define SUP_CTRL_CLR_SEC  3
`define SUP_CTRL_INJ_PRIM 4
`define SUP_CTRL_INJ_SEC  5

// reset values
`define SUP_CFG_RESET   8'h00
`define SUP_PINS_RESET  6'h00

// timing counts: dividers in pclk cycles per tick, lifesign period and window in ticks of each die's oscillator
`define SUP_PRIM_DIV    4
`define SUP_SEC_DIV     4
`define SUP_LS_PERIOD   16
`define SUP_LS_WINDOW   24

`endif

// >>> supervision_pkg.sv
// types shared by the supervision block: operating modes and carriers.
// assumes supervision_defines.svh sits in the same folder.
`include "supervision_defines.svh"

package supervision_pkg;

  // operating modes of the primary control state machine
  typedef enum logic [2:0] {
    default_reset_mode,
    active_mode_one,
    class_a_halt_mode_one,
    active_mode_two,
    class_a_halt_mode_two
  } mode_e;

  // filtered pin levels, bit order fixed by the synchroniser
  typedef struct packed {
    logic enable_pin_level;
    logic disable_level;
    logic prim_ref_fault;
    logic sec_ref_fault;
    logic prim_osc_ok;
    logic sec_osc_ok;
  } pins_s;

  // live status word as read by software
  typedef struct packed {
    logic [20:0] pad;
    mode_e       mode;
    logic        sec_hold;
    logic        prim_hold;
    logic        fault_b;
    logic        fault_a;
    logic        secondary_ready_status;
    logic        enable_valid_flag;
    logic        enable_pin_level;
  } status_s;

endpackage

// >>> supervision_top.sv
// enable pin handling and mutual lifesign, reference-pin and parity
// supervision of a two-die gate driver, with an APB register slave.
// assumes pin inputs are asynchronous and each die's oscillator is
// modelled by a tick divider on pclk.
//
// Added by the designer: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "supervision_defines.svh"

module supervision_top #(
  parameter int PRIM_DIV  = `SUP_PRIM_DIV,
  parameter int SEC_DIV   = `SUP_SEC_DIV,
  parameter int LS_PERIOD = `SUP_LS_PERIOD,
  parameter int LS_WINDOW = `SUP_LS_WINDOW
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire logic        enable_pin,
  input  wire logic        output_disable_input,
  input  wire logic        primary_bias_reference_pin_fault,
  input  wire logic        secondary_bias_reference_pin_fault,
  input  wire logic        primary_oscillator_ok,
  input  wire logic        secondary_oscillator_ok,
  output logic             fault_class_a_n,
  output logic             fault_class_b_n,
  output logic             reset_ready_n,
  output logic             gate_off,
  output logic             output_tristate,
  output logic             emergency_turn_off
);

  // refuse settings the counters cannot serve
  if (PRIM_DIV < 1 || SEC_DIV < 1 || PRIM_DIV > 65535 || SEC_DIV > 65535)
    $error("divider out of range");
  if (LS_PERIOD < 1 || LS_WINDOW <= LS_PERIOD || LS_WINDOW > 65535)
    $error("lifesign window must exceed period");

  // register select, used by read and write paths
  function automatic logic [2:0] reg_sel(input logic [7:0] a);
    if (a == `SUP_OFS_CTRL)        reg_sel = 3'h1;
    else if (a == `SUP_OFS_STATUS) reg_sel = 3'h2;
    else if (a == `SUP_OFS_ERRORS) reg_sel = 3'h3;
    else if (a == `SUP_OFS_PCFG)   reg_sel = 3'h4;
    else if (a == `SUP_OFS_SCFG)   reg_sel = 3'h5;
    else                           reg_sel = 3'h0;
  endfunction

  // three-stage pin synchronisers with agreement filter
  logic [5:0] sync1_q;
  logic [5:0] sync2_q;
  logic [5:0] sync3_q;
  logic [5:0] filt_q;
  wire  [5:0] pin_raw;
  wire  [5:0] filt_d;
  supervision_pkg::pins_s pins;

  assign pin_raw = {enable_pin, output_disable_input,
                    primary_bias_reference_pin_fault,
                    secondary_bias_reference_pin_fault,
                    primary_oscillator_ok, secondary_oscillator_ok};
  assign filt_d = (sync2_q & sync3_q) | (filt_q & (sync2_q ^ sync3_q));
  assign pins   = supervision_pkg::pins_s'(filt_q);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_q <= `SUP_PINS_RESET;
      sync2_q <= `SUP_PINS_RESET;
      sync3_q <= `SUP_PINS_RESET;
      filt_q  <= `SUP_PINS_RESET;
    end else begin
      sync1_q <= pin_raw;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      filt_q  <= filt_d;
    end
  end

  // state
  supervision_pkg::mode_e mode_q, mode_d;
  logic [7:0] pcfg_q;
  logic       pcfg_par_q;
  logic [7:0] scfg_q;
  logic       scfg_par_q;
  logic       prim_par_lock_q;
  logic       en_prev_q;
  logic       fault_a_q;
  logic       fault_b_q;
  logic       prim_loss_q;
  logic       sec_loss_q;
  logic       en_event_q;
  logic       sec_par_seen_q;
  logic       link_up_q;
  logic       eto_src_q;
  logic       rr_q;
  logic       gate_off_q;
  logic       tristate_q;
  logic       eto_q;
  logic [31:0] rdata_q;

  wire enable_valid = pins.enable_pin_level;
  wire en_fall      = en_prev_q & ~pins.enable_pin_level;
  wire en_rise      = ~en_prev_q & pins.enable_pin_level;

  wire prim_par_err = ^{pcfg_q, pcfg_par_q};
  wire sec_par_err  = ^{scfg_q, scfg_par_q};

  wire prim_hold = pins.prim_ref_fault | ~pins.prim_osc_ok | prim_par_lock_q;
  wire sec_hold  = pins.sec_ref_fault | ~pins.sec_osc_ok | sec_par_err;
  wire [1:0] die_run = {~sec_hold, ~prim_hold};

  // lifesign sender and watchdog per die
  wire [1:0] ls_tx;
  wire [1:0] ls_err;
  for (genvar i = 0; i < 2; i++) begin : g_die
    localparam int DIV = (i == 0) ? PRIM_DIV : SEC_DIV;
    localparam logic [15:0] DIV_LAST = 16'(DIV - 1);
    localparam logic [15:0] PER_LAST = 16'(LS_PERIOD - 1);
    localparam logic [15:0] WIN_LAST = 16'(LS_WINDOW - 1);
    logic [15:0] div_q;
    logic [15:0] per_q;
    logic [15:0] wd_q;
    logic        tx_q;
    wire tick = die_run[i] & (div_q == DIV_LAST);
    wire rx   = ls_tx[1 - i];

    assign ls_tx[i]  = tx_q;
    assign ls_err[i] = tick & (wd_q == WIN_LAST) & ~rx;

    // period and window in local ticks
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        div_q <= 16'h0000;
        per_q <= 16'h0000;
        wd_q  <= 16'h0000;
        tx_q  <= 1'b0;
      end else if (!die_run[i]) begin
        div_q <= 16'h0000;
        per_q <= 16'h0000;
        wd_q  <= 16'h0000;
        tx_q  <= 1'b0;
      end else begin
        div_q <= tick ? 16'h0000 : div_q + 16'h0001;
        tx_q  <= tick & (per_q == PER_LAST);
        if (tick)
          per_q <= (per_q == PER_LAST) ? 16'h0000 : per_q + 16'h0001;
        if (rx || ls_err[i])
          wd_q <= 16'h0000;
        else if (tick)
          wd_q <= wd_q + 16'h0001;
      end
    end
  end

  wire ls_err_any = |ls_err;

  // apb decode
  wire       setup   = psel & ~penable;
  wire       access  = psel & penable;
  wire [2:0] sel     = reg_sel(paddr);
  wire       bad     = (sel == 3'h0) | prim_hold;
  wire       wr      = access & pwrite & ~bad & pstrb[0];
  wire       wr_ctrl = wr & (sel == 3'h1);
  wire       go      = wr_ctrl & pwdata[`SUP_CTRL_GO];
  wire       clr_p   = wr_ctrl & pwdata[`SUP_CTRL_CLR_PRIM];
  wire       clr_s   = wr_ctrl & pwdata[`SUP_CTRL_CLR_SEC];
  wire       halted  = (mode_q == supervision_pkg::class_a_halt_mode_one) |
                       (mode_q == supervision_pkg::class_a_halt_mode_two);
  wire       active  = (mode_q == supervision_pkg::active_mode_one) |
                       (mode_q == supervision_pkg::active_mode_two);
  wire       to_halt = en_fall & active;
  wire       eto_src = pins.sec_ref_fault | sec_par_err | prim_par_lock_q;

  assign pready  = 1'b1;
  assign pslverr = access & bad;
  assign prdata  = rdata_q;

  supervision_pkg::status_s status;
  // raw level and validity reported apart
  assign status = '{pad: 21'h000000, mode: mode_q, sec_hold: sec_hold,
                    prim_hold: prim_hold, fault_b: fault_b_q,
                    fault_a: fault_a_q, secondary_ready_status: link_up_q,
                    enable_valid_flag: enable_valid,
                    enable_pin_level: pins.enable_pin_level};

  wire [31:0] rd_mux =
    (sel == 3'h2) ? 32'(status) :
    (sel == 3'h3) ? {27'h0000000, sec_par_seen_q, prim_par_lock_q,
                     en_event_q, sec_loss_q, prim_loss_q} :
    (sel == 3'h4) ? {24'h000000, pcfg_q} :
    (sel == 3'h5) ? {24'h000000, scfg_q} : 32'h00000000;

  // mode state machine
  always_comb begin
    mode_d = mode_q;
    case (mode_q)
      supervision_pkg::default_reset_mode: begin
        if (go && enable_valid && link_up_q)
          mode_d = pwdata[`SUP_CTRL_MODE_TWO] ?
                   supervision_pkg::active_mode_two :
                   supervision_pkg::active_mode_one;
      end
      supervision_pkg::active_mode_one: begin
        if (en_fall) mode_d = supervision_pkg::class_a_halt_mode_one;
      end
      supervision_pkg::active_mode_two: begin
        if (en_fall) mode_d = supervision_pkg::class_a_halt_mode_two;
      end
      supervision_pkg::class_a_halt_mode_one: begin
        if (go && enable_valid) mode_d = supervision_pkg::active_mode_one;
      end
      supervision_pkg::class_a_halt_mode_two: begin
        if (go && enable_valid) mode_d = supervision_pkg::active_mode_two;
      end
      default: mode_d = supervision_pkg::default_reset_mode;
    endcase
    if (ls_err_any || prim_hold)
      mode_d = supervision_pkg::default_reset_mode;
  end

  // mode, enable history and read data
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q    <= supervision_pkg::default_reset_mode;
      en_prev_q <= 1'b0;
      rdata_q   <= 32'h00000000;
    end else begin
      mode_q    <= mode_d;
      en_prev_q <= pins.enable_pin_level;
      if (setup)
        rdata_q <= bad ? 32'h00000000 : rd_mux;
    end
  end

  // configuration words with hardware-made parity
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pcfg_q     <= `SUP_CFG_RESET;
      pcfg_par_q <= ^`SUP_CFG_RESET;
      scfg_q     <= `SUP_CFG_RESET;
      scfg_par_q <= ^`SUP_CFG_RESET;
    end else begin
      if (wr && sel == 3'h4) begin
        pcfg_q     <= pwdata[7:0];
        pcfg_par_q <= ^pwdata[7:0];
      end else if (wr_ctrl && pwdata[`SUP_CTRL_INJ_PRIM]) begin
        pcfg_par_q <= ~pcfg_par_q;
      end
      if (wr && sel == 3'h5) begin
        scfg_q     <= pwdata[7:0];
        scfg_par_q <= ^pwdata[7:0];
      end else if (wr_ctrl && pwdata[`SUP_CTRL_INJ_SEC]) begin
        scfg_par_q <= ~scfg_par_q;
      end
    end
  end

  // fault notifications and sticky flags, set beats clear; for the link ready flag, clear beats set
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_a_q       <= 1'b0;
      fault_b_q       <= 1'b0;
      prim_loss_q     <= 1'b0;
      sec_loss_q      <= 1'b0;
      en_event_q      <= 1'b0;
      sec_par_seen_q  <= 1'b0;
      prim_par_lock_q <= 1'b0;
      link_up_q       <= 1'b0;
    end else begin
      // class A pin only on halt entry
      if (to_halt)
        fault_a_q <= 1'b1;
      // enable return clears in halt only
      else if ((en_rise && halted) || clr_p)
        fault_a_q <= 1'b0;
      if (ls_err_any || prim_par_lock_q || prim_hold)
        fault_b_q <= 1'b1;
      else if ((en_rise && halted) || clr_p)
        fault_b_q <= 1'b0;
      // both loss flags on lifesign error
      if (ls_err_any)
        prim_loss_q <= 1'b1;
      else if (clr_p)
        prim_loss_q <= 1'b0;
      if (ls_err_any)
        sec_loss_q <= 1'b1;
      else if (clr_s)
        sec_loss_q <= 1'b0;
      // falling enable logged as class A
      if (en_fall)
        en_event_q <= 1'b1;
      else if (clr_p)
        en_event_q <= 1'b0;
      if (sec_par_err)
        sec_par_seen_q <= 1'b1;
      else if (clr_s)
        sec_par_seen_q <= 1'b0;
      if (prim_par_err)
        prim_par_lock_q <= 1'b1;
      if (ls_err_any || sec_hold || prim_hold)
        link_up_q <= 1'b0;
      else if (ls_tx[1])
        link_up_q <= 1'b1;
    end
  end

  // pin outputs from flip-flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rr_q       <= 1'b0;
      gate_off_q <= 1'b1;
      tristate_q <= 1'b0;
      eto_src_q  <= 1'b0;
      eto_q      <= 1'b0;
    end else begin
      rr_q       <= prim_hold;
      gate_off_q <= ~enable_valid | ~active | sec_hold | prim_hold;
      tristate_q <= pins.disable_level & pins.sec_osc_ok;
      eto_src_q  <= eto_src;
      eto_q      <= eto_src & ~eto_src_q;
    end
  end

  assign fault_class_a_n    = ~fault_a_q;
  assign fault_class_b_n    = ~fault_b_q;
  assign reset_ready_n      = ~rr_q;
  assign gate_off           = gate_off_q;
  assign output_tristate    = tristate_q;
  assign emergency_turn_off = eto_q;

  // checks
  property p_halt_entry;
    @(posedge pclk) disable iff (!presetn)
    (en_fall && mode_q == supervision_pkg::active_mode_one && !prim_hold &&
     !ls_err_any) |=> (mode_q == supervision_pkg::class_a_halt_mode_one &&
                       !fault_class_a_n);
  endproperty
  a_halt_entry: assert property (p_halt_entry)
    else $error("enable fall did not halt with class A");

  property p_rise_clear;
    @(posedge pclk) disable iff (!presetn)
    (en_rise && halted) |=> fault_class_a_n;
  endproperty
  a_rise_clear: assert property (p_rise_clear)
    else $error("class A not cleared on enable return");

  property p_fault_a_cause;
    @(posedge pclk) disable iff (!presetn)
    $fell(fault_class_a_n) |-> $past(to_halt);
  endproperty
  a_fault_a_cause: assert property (p_fault_a_cause)
    else $error("class A asserted without halt entry");

  property p_ls_reset;
    @(posedge pclk) disable iff (!presetn)
    ls_err_any |=> (mode_q == supervision_pkg::default_reset_mode &&
                    !fault_class_b_n && prim_loss_q && sec_loss_q &&
                    !link_up_q);
  endproperty
  a_ls_reset: assert property (p_ls_reset)
    else $error("lifesign error reaction missing");

  property p_par_forever;
    @(posedge pclk) disable iff (!presetn)
    prim_par_err |=> ##1 (!reset_ready_n && !fault_class_b_n)[*8];
  endproperty
  a_par_forever: assert property (p_par_forever)
    else $error("reset_ready released after primary parity");

  property p_pref_hold;
    @(posedge pclk) disable iff (!presetn)
    pins.prim_ref_fault |=> !reset_ready_n && pslverr == (psel && penable);
  endproperty
  a_pref_hold: assert property (p_pref_hold)
    else $error("primary reference fault not holding");

  property p_sec_gate;
    @(posedge pclk) disable iff (!presetn)
    (sec_hold || !enable_valid) |=> gate_off;
  endproperty
  a_sec_gate: assert property (p_sec_gate)
    else $error("gate not commanded off");

  property p_wd_bound;
    @(posedge pclk) disable iff (!presetn)
    (die_run[0] && ls_tx[1]) |-> ##[1:1000] (ls_tx[1] || ls_err[0] ||
                                            !die_run[0]);
  endproperty
  a_wd_bound: assert property (p_wd_bound)
    else $error("primary watchdog never concluded");

  property p_eto;
    @(posedge pclk) disable iff (!presetn)
    ($rose(sec_par_err) && !eto_src_q) |=> emergency_turn_off;
  endproperty
  a_eto: assert property (p_eto)
    else $error("no turn-off on secondary parity");

  c_halt:    cover property (@(posedge pclk) disable iff (!presetn)
                             to_halt);
  c_ls_err:  cover property (@(posedge pclk) disable iff (!presetn)
                             ls_err_any);
  c_link_up: cover property (@(posedge pclk) disable iff (!presetn)
                             $rose(link_up_q));

endmodule
`default_nettype wire

// >>> host_model.sv
// host side model: apb master transfers and the supervised pin levels.
// assumes it is called from the bench just after a rising pclk edge.
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input  wire logic                    pclk,
  output logic                         psel,
  output logic                         penable,
  output logic                         pwrite,
  output logic [7:0]                   paddr,
  output logic [31:0]                  pwdata,
  output logic [3:0]                   pstrb,
  input  wire logic                    pready,
  input  wire logic [31:0]             prdata,
  input  wire logic                    pslverr,
  output supervision_pkg::pins_s       pins
);
  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0;
    pstrb   = 4'h0;
    pins    = 6'h03;
  end

  // one transfer: setup, then access held until pready high
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] r,
                      output logic e, input logic [3:0] s = 4'hf);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    pstrb   <= w ? s : 4'h0;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic set_pins(input supervision_pkg::pins_s p);
    pins <= p;
  endtask
endmodule
`default_nettype wire

// >>> enable_and_internal_supervision_tb.sv
// self-checking bench of the supervision block with short lifesign counts.
// assumes host_model drives the bus and the pins.
`timescale 1ns/1ps
`default_nettype none
module enable_and_internal_supervision_tb;
  logic                   pclk;
  logic                   presetn;
  logic                   psel, penable, pwrite, pready, pslverr, err;
  logic [7:0]             paddr;
  logic [3:0]             pstrb;
  logic [31:0]            pwdata, prdata, rd;
  logic                   fa_n, fb_n, rr_n, g_off, tri_o, eto;
  supervision_pkg::pins_s pins;
  int                     miscompares;
  int                     checks_done;
  wire logic [5:0]        outs;
  logic [31:0]            act_m[2] = '{32'h80, 32'h180};
  logic [31:0]            halt_m[2] = '{32'h100, 32'h200};

  assign outs = {fa_n, fb_n, rr_n, g_off, tri_o, eto};
  always #2 pclk = ~pclk;

  host_model u_host_model (.pclk(pclk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .pins(pins));

  supervision_top #(.PRIM_DIV(2), .SEC_DIV(2), .LS_PERIOD(4),
    .LS_WINDOW(6)) u_supervision_top (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .enable_pin(pins.enable_pin_level),
    .output_disable_input(pins.disable_level),
    .primary_bias_reference_pin_fault(pins.prim_ref_fault),
    .secondary_bias_reference_pin_fault(pins.sec_ref_fault),
    .primary_oscillator_ok(pins.prim_osc_ok),
    .secondary_oscillator_ok(pins.sec_osc_ok), .fault_class_a_n(fa_n),
    .fault_class_b_n(fb_n), .reset_ready_n(rr_n), .gate_off(g_off),
    .output_tristate(tri_o), .emergency_turn_off(eto));

  // value compare
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string what);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // read with mask, or write, both expecting an accepted transfer
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] m,
                        input logic [31:0] e, input string what);
    u_host_model.xfer(1'b0, a, 32'h0, rd, err);
    chk({31'h0, err}, 32'h0, "bus error");
    chk(rd & m, e, what);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    u_host_model.xfer(1'b1, a, d, rd, err);
    chk({31'h0, err}, 32'h0, "write error");
  endtask

  // wait for an output level, or watch it hold for a span
  task automatic wait_out(input int i, input logic v, input int lim,
                          input string what);
    int n;
    n = 0;
    do begin
      @(negedge pclk);
      n++;
    end while (outs[i] !== v && n < lim);
    chk({31'h0, outs[i]}, {31'h0, v}, what);
    @(posedge pclk);
  endtask
  task automatic hold_out(input int i, input logic v, input int c,
                          input string what);
    logic bad;
    bad = 1'b0;
    repeat (c) begin
      @(negedge pclk);
      if (outs[i] !== v) bad = 1'b1;
    end
    chk({31'h0, bad}, 32'h0, what);
    @(posedge pclk);
  endtask

  // reset with given pin levels, then poll for the secondary link
  task automatic rst(input supervision_pkg::pins_s p);
    presetn <= 1'b0;
    u_host_model.set_pins(p);
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    repeat (12) @(posedge pclk);
  endtask
  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      u_host_model.xfer(1'b0, 8'h04, 32'h0, rd, err);
      n++;
    end while (rd[2] !== 1'b1 && n < 30);
    chk({31'h0, rd[2]}, 32'h1, "secondary ready");
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // watchdog against a hung handshake or wait
  initial begin
    #100000;
    miscompares++;
    $display("Error %0t: watchdog expired", $time);
    finish_test();
  end

  // main sequence
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    miscompares = 0;
    checks_done = 0;
    @(posedge pclk);
    rst(6'h23);
    chk({29'h0, fa_n, fb_n, g_off}, 32'h5, "reset outputs");
    rd_chk(8'h04, 32'h383, 32'h3, "reset status");
    u_host_model.xfer(1'b0, 8'h14, 32'h0, rd, err);
    chk({31'h0, err}, 32'h1, "unmapped error");
    chk(rd, 32'h0, "unmapped data");
    rd_chk(8'h00, 32'hffffffff, 32'h0, "ctrl reads zero");
    wr(8'h0c, 32'h5a);
    rd_chk(8'h0c, 32'hffffffff, 32'h5a, "primary cfg");
    u_host_model.xfer(1'b1, 8'h0c, 32'h11, rd, err, 4'h0);
    rd_chk(8'h0c, 32'hffffffff, 32'h5a, "strobe gates write");
    $display("test reset and registers done");
    for (int m = 0; m < 2; m++) begin
      rst(6'h23);
      wait_ready();
      wr(8'h00, m ? 32'h3 : 32'h1);
      rd_chk(8'h04, 32'h380, act_m[m], "active mode");
      u_host_model.set_pins(6'h03);
      wait_out(5, 1'b0, 20, "class a on fall");
      rd_chk(8'h04, 32'h382, halt_m[m], "halt mode");
      chk({31'h0, g_off}, 32'h1, "gate off in halt");
      rd_chk(8'h08, 32'h4, 32'h4, "enable event flag");
      u_host_model.set_pins(6'h23);
      wait_out(5, 1'b1, 20, "class a cleared");
    end
    u_host_model.set_pins(6'h03);
    hold_out(5, 1'b1, 20, "no class a outside active");
    u_host_model.set_pins(6'h23);
    $display("test enable done");
    rst(6'h23);
    wait_ready();
    wr(8'h00, 32'h4);
    wait_out(4, 1'b1, 10, "class b clear before");
    u_host_model.set_pins(6'h27);
    wait_out(0, 1'b1, 20, "turn-off on sec ref");
    wait_out(4, 1'b0, 80, "class b on lifesign");
    rd_chk(8'h04, 32'h384, 32'h0, "mode zero no ready");
    rd_chk(8'h08, 32'h3, 32'h3, "both loss flags");
    u_host_model.set_pins(6'h37);
    wait_out(1, 1'b1, 20, "tristate works");
    chk({31'h0, g_off}, 32'h1, "gate off");
    u_host_model.set_pins(6'h23);
    wait_ready();
    wr(8'h00, 32'hc);
    wait_out(4, 1'b1, 10, "class b cleared");
    rd_chk(8'h08, 32'h3, 32'h0, "loss flags cleared");
    u_host_model.set_pins(6'h2b);
    wait_out(3, 1'b0, 20, "prim ref holds");
    u_host_model.set_pins(6'h23);
    wait_out(3, 1'b1, 40, "prim ref released");
    $display("test reference pins done");
    rst(6'h23);
    wait_ready();
    wr(8'h00, 32'h24);
    wait_out(0, 1'b1, 20, "turn-off on sec parity");
    wait_out(4, 1'b0, 80, "lifesign after sec parity");
    rst(6'h23);
    wait_ready();
    wr(8'h00, 32'h14);
    wait_out(3, 1'b0, 20, "prim parity holds");
    wait_out(4, 1'b0, 20, "prim parity class b");
    hold_out(3, 1'b0, 100, "held low for good");
    u_host_model.xfer(1'b0, 8'h04, 32'h0, rd, err);
    chk({31'h0, err}, 32'h1, "bus refused held");
    $display("test parity done");
    rst(6'h21);
    hold_out(3, 1'b0, 20, "no prim oscillator");
    u_host_model.xfer(1'b0, 8'h04, 32'h0, rd, err);
    chk({31'h0, err}, 32'h1, "bus refused no osc");
    rst(6'h22);
    wr(8'h00, 32'h4);
    wait_out(4, 1'b0, 60, "no sec oscillator");
    rd_chk(8'h04, 32'h4, 32'h0, "ready stays zero");
    rd_chk(8'h08, 32'h1, 32'h1, "primary loss flag");
    $display("test oscillators done");
    finish_test();
  end
endmodule
`default_nettype wire
